// ===== core/chrb_params.svh
// constants for the charger control register bank
// Operation
// - target answers at seven-bit address 0x6B
// - offsets 0-7 writable, 8-A read-only
// - input bit 7 enables high impedance
// - voltage limit bits 6:3, reset 1011
// - current limit code bits 2:0 decode
// - default current code follows detected source
// - applied current limit is lower one
// - register reset bit restores field defaults
// - boost enable overrides charge enable
// - bit 4 enables battery charging
// - minimum system voltage bits 3:1, 101
// - fast charge current bits 7:2, 011000
// - bit 1 selects boost cold threshold
// - force bit scales charge currents down
// - reset values 0x58, 0x1B, 0x60
`ifndef CHRB_PARAMS_SVH
`define CHRB_PARAMS_SVH
`define CHRB_TARGET_ADDR 7'h6B
`define CHRB_OFS_INPUT 8'h00
`define CHRB_OFS_POWER 8'h01
`define CHRB_OFS_CHARGE 8'h02
`define CHRB_OFS_LAST_RW 8'h07
`define CHRB_OFS_LAST_RO 8'h0A
`define CHRB_RST_INPUT 8'h58
`define CHRB_RST_POWER 8'h1B
`define CHRB_RST_CHARGE 8'h60
`define CHRB_BIT_HIZ 7
`define CHRB_BIT_REGRST 7
`define CHRB_BIT_WDRST 6
`define CHRB_BIT_BOOST 5
`define CHRB_BIT_CHG 4
`define CHRB_BIT_COLD 1
`define CHRB_BIT_FORCE 0
`define CHRB_INLIM_SDP 3'h2
`define CHRB_INLIM_DCP 3'h5
`define CHRB_INLIM_DIV12 3'h6
`define CHRB_INLIM_DIV3 3'h4
`endif

// ===== core/chrb_pkg.sv
// types for the charger control register bank
package chrb_pkg;
  typedef enum logic [1:0] {CHRB_SRC_SDP, CHRB_SRC_DCP, CHRB_SRC_DIV12, CHRB_SRC_DIV3} chrb_src_t;
  typedef enum logic [2:0] {CHRB_IDLE, CHRB_ADDR, CHRB_ACK, CHRB_WRX, CHRB_RTX, CHRB_RACK,
    CHRB_SKIP} chrb_state_t;
endpackage : chrb_pkg

// ===== core/chrb_register_bank.sv
// I2C target with the input, power-on and charge current registers
`timescale 1ns/1ns
`include "chrb_params.svh"
module chrb_register_bank (
  input wire logic clock,
  input wire logic resetn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire chrb_pkg::chrb_src_t detected_source,
  input wire logic [2:0] external_current_limit_pin,
  input wire logic [7:0] status_reg8,
  input wire logic [7:0] status_reg9,
  input wire logic [7:0] status_reg10,
  output logic [7:0] ext_wr_data,
  output logic [2:0] ext_wr_offset,
  output logic ext_wr_strobe,
  input wire logic [7:0] ext_rd_data,
  output logic high_impedance_enable,
  output logic [3:0] input_voltage_limit,
  output logic [2:0] input_current_limit,
  output logic [2:0] applied_current_limit,
  output logic watchdog_reset_pulse,
  output logic boost_output_enable,
  output logic charge_enable,
  output logic [2:0] minimum_system_voltage,
  output logic [5:0] fast_charge_current,
  output logic boost_cold_select,
  output logic reduced_charge_current_force
);
  import chrb_pkg::*;

  // three-stage synchronisers; a change counts once stages two and three agree
  logic [2:0] scl_s_q, sda_s_q;
  logic scl_q, sda_q, scl_prev_q, sda_prev_q;
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
    end
    else
    begin
      scl_s_q <= {scl_s_q[1:0], scl_in};
      sda_s_q <= {sda_s_q[1:0], sda_in};
    end
  end

  // filtered levels keep the old value while stages disagree
  wire scl_d = (scl_s_q[1] == scl_s_q[2]) ? scl_s_q[2] : scl_q;
  wire sda_d = (sda_s_q[1] == sda_s_q[2]) ? sda_s_q[2] : sda_q;
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl_d;
      sda_q <= sda_d;
      scl_prev_q <= scl_q;
      sda_prev_q <= sda_q;
    end
  end

  // bus events
  wire scl_rise = scl_q && !scl_prev_q;
  wire scl_fall = !scl_q && scl_prev_q;
  wire start_cond = scl_q && scl_prev_q && !sda_q && sda_prev_q;
  wire stop_cond = scl_q && scl_prev_q && sda_q && !sda_prev_q;

  // protocol state
  chrb_state_t state_q;
  logic [7:0] shift_q, ptr_q, tx_q;
  logic [3:0] bit_q;
  logic first_q, rw_q, ack_q, nack_q;

  wire byte_done = scl_rise && (bit_q == 4'h7);
  wire [7:0] rx_byte = {shift_q[6:0], sda_q};
  wire addr_hit = (rx_byte[7:1] == `CHRB_TARGET_ADDR);
  wire in_range = (ptr_q <= `CHRB_OFS_LAST_RO);
  wire ptr_writable = (ptr_q <= `CHRB_OFS_LAST_RW);

  // register file
  logic [7:0] input_q, power_q, charge_q;
  logic [7:0] input_d, power_d, charge_d;
  logic [7:0] rd_mux;
  logic wdrst_q;
  // one-shot flag: the first edge after reset loads the source default, as a register reset write also does
  logic boot_q;

  wire [2:0] curlim_default = (detected_source == CHRB_SRC_SDP) ? `CHRB_INLIM_SDP :
    (detected_source == CHRB_SRC_DCP) ? `CHRB_INLIM_DCP :
    (detected_source == CHRB_SRC_DIV12) ? `CHRB_INLIM_DIV12 : `CHRB_INLIM_DIV3;
  wire [7:0] input_default = {`CHRB_RST_INPUT & 8'hF8} | {5'h00, curlim_default};

  // write decode, a write takes effect on the data byte's eighth clock
  wire wr_fire = (state_q == CHRB_WRX) && byte_done && !first_q && ptr_writable;
  wire wr_in = wr_fire && (ptr_q == `CHRB_OFS_INPUT);
  wire wr_pw = wr_fire && (ptr_q == `CHRB_OFS_POWER);
  wire wr_ch = wr_fire && (ptr_q == `CHRB_OFS_CHARGE);
  wire reg_reset = wr_pw && rx_byte[`CHRB_BIT_REGRST];

  // next register values; reset bit and watchdog bit self-clear
  always_comb
  begin
    input_d = input_q;
    power_d = power_q;
    charge_d = charge_q;
    if (reg_reset)
    begin
      input_d = input_default;
      power_d = `CHRB_RST_POWER;
      charge_d = `CHRB_RST_CHARGE;
    end
    else
    begin
      if (wr_in)
        input_d = rx_byte;
      if (wr_pw)
        power_d = {2'b00, rx_byte[5:1], 1'b1};
      if (wr_ch)
        charge_d = rx_byte;
    end
  end

  // reset values; input limit default loaded after release via
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      input_q <= `CHRB_RST_INPUT;
      power_q <= `CHRB_RST_POWER;
      charge_q <= `CHRB_RST_CHARGE;
      wdrst_q <= 1'b0;
      first_q <= 1'b1;
      boot_q <= 1'b1;
    end
    else
    begin
      boot_q <= 1'b0;
      input_q <= boot_q ? input_default : input_d;
      power_q <= power_d;
      charge_q <= charge_d;
      wdrst_q <= wr_pw && !reg_reset && rx_byte[`CHRB_BIT_WDRST];
      first_q <= (state_q == CHRB_ADDR) ? 1'b1 :
        ((state_q == CHRB_WRX) && byte_done) ? 1'b0 : (first_q && state_q != CHRB_IDLE);
    end
  end

  // read mux, offsets 3-7 belong to the bank beyond this block
  assign rd_mux = !in_range ? 8'h00 :
    (ptr_q == `CHRB_OFS_INPUT) ? input_q :
    (ptr_q == `CHRB_OFS_POWER) ? power_q :
    (ptr_q == `CHRB_OFS_CHARGE) ? charge_q :
    (ptr_q == 8'h08) ? status_reg8 :
    (ptr_q == 8'h09) ? status_reg9 :
    (ptr_q == 8'h0A) ? status_reg10 : ext_rd_data;

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= CHRB_IDLE;
      shift_q <= 8'h00;
      bit_q <= 4'h0;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      ack_q <= 1'b0;
      tx_q <= 8'h00;
      nack_q <= 1'b0;
    end
    else if (start_cond)
    begin
      state_q <= CHRB_ADDR;
      bit_q <= 4'h0;
      ack_q <= 1'b0;
    end
    else if (stop_cond)
    begin
      state_q <= CHRB_IDLE;
      ack_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        CHRB_IDLE: ack_q <= 1'b0;
        CHRB_ADDR, CHRB_WRX:
        begin
          if (scl_rise)
          begin
            shift_q <= rx_byte;
            bit_q <= bit_q + 4'h1;
          end
          if (byte_done)
          begin
            if (state_q == CHRB_ADDR)
            begin
              rw_q <= rx_byte[0];
              state_q <= addr_hit ? CHRB_ACK : CHRB_SKIP;
            end
            else
            begin
              state_q <= CHRB_ACK;
              if (first_q)
                ptr_q <= rx_byte;
              else
                ptr_q <= ptr_q + 8'h01;
            end
          end
        end
        CHRB_ACK:
        begin
          // drive ack low through the ninth clock
          if (scl_fall)
            ack_q <= !ack_q;
          if (scl_fall && ack_q)
          begin
            bit_q <= 4'h0;
            if (rw_q)
            begin
              state_q <= CHRB_RTX;
              tx_q <= rd_mux;
              ack_q <= 1'b0;
            end
            else
              state_q <= CHRB_WRX;
          end
        end
        CHRB_RTX:
        begin
          if (scl_fall)
          begin
            bit_q <= bit_q + 4'h1;
            tx_q <= {tx_q[6:0], 1'b0};
            if (bit_q == 4'h7)
              state_q <= CHRB_RACK;
          end
        end
        CHRB_RACK:
        begin
          // pointer steps on the acknowledge clock so the next byte loads fresh data
          if (scl_rise)
          begin
            nack_q <= sda_q;
            ptr_q <= ptr_q + 8'h01;
          end
          if (scl_fall)
          begin
            bit_q <= 4'h0;
            state_q <= nack_q ? CHRB_SKIP : CHRB_RTX;
            tx_q <= rd_mux;
          end
        end
        CHRB_SKIP: ack_q <= 1'b0;
        default: state_q <= CHRB_IDLE;
      endcase
    end
  end

  // second read byte loads after pointer step
  wire read_bit = (state_q == CHRB_RTX) ? tx_q[7] : 1'b1;
  // open drain: enable only while pulling low
  assign sda_out = 1'b0;
  assign sda_oe = ack_q || ((state_q == CHRB_RTX) && !read_bit);

  // offsets 3-7 pass to the outer bank
  assign ext_wr_strobe = wr_fire && (ptr_q > `CHRB_OFS_CHARGE);
  assign ext_wr_offset = ptr_q[2:0];
  assign ext_wr_data = rx_byte;

  assign high_impedance_enable = input_q[`CHRB_BIT_HIZ];
  assign input_voltage_limit = input_q[6:3];
  assign input_current_limit = input_q[2:0];
  // lower of register and pin limits
  assign applied_current_limit = (input_q[2:0] < external_current_limit_pin) ?
    input_q[2:0] : external_current_limit_pin;
  // pulse only; spacing is the host's duty
  assign watchdog_reset_pulse = wdrst_q;
  assign boost_output_enable = power_q[`CHRB_BIT_BOOST];
  assign charge_enable = power_q[`CHRB_BIT_CHG] && !power_q[`CHRB_BIT_BOOST];
  assign minimum_system_voltage = power_q[3:1];
  assign fast_charge_current = charge_q[7:2];
  assign boost_cold_select = charge_q[`CHRB_BIT_COLD];
  assign reduced_charge_current_force = charge_q[`CHRB_BIT_FORCE];
endmodule : chrb_register_bank

// ===== testbench/chrb_checker.sv
// port assertions for the charger register bank
`timescale 1ns/1ns
module chrb_checker (
  input wire logic clock,
  input wire logic resetn,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic ext_wr_strobe,
  input wire logic [2:0] ext_wr_offset,
  input wire logic [2:0] input_current_limit,
  input wire logic [2:0] external_current_limit_pin,
  input wire logic [2:0] applied_current_limit,
  input wire logic watchdog_reset_pulse,
  input wire logic boost_output_enable,
  input wire logic charge_enable,
  input wire logic [2:0] minimum_system_voltage,
  input wire logic [5:0] fast_charge_current
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // fields move only after an scl rise, never deep in a low phase
  wire [9:0] flds = {boost_output_enable, minimum_system_voltage, fast_charge_current};
  sequence scl_low_run;
    !scl_in [*8];
  endsequence
  sequence scl_high_run;
    scl_in [*6];
  endsequence
  a_fields_low_quiet: assert property (scl_low_run |-> $stable(flds))
    else $error("field moved in scl low");
  a_oe_high_hold: assert property (scl_high_run |-> $stable(sda_oe))
    else $error("sda moved in scl high");
  a_boost_wins: assert property (boost_output_enable |-> !charge_enable)
    else $error("charge with boost");
  a_applied_lower: assert property (applied_current_limit <= input_current_limit &&
    applied_current_limit <= external_current_limit_pin &&
    (applied_current_limit == input_current_limit ||
    applied_current_limit == external_current_limit_pin))
    else $error("applied limit not lower");
  a_reset_defaults: assert property ($rose(resetn) |-> flds == 10'h158 && charge_enable)
    else $error("reset value wrong");
  a_strobe_upper: assert property (ext_wr_strobe |-> ext_wr_offset >= 3'h3 ##1 !ext_wr_strobe)
    else $error("outer strobe wrong");
  a_wdog_single: assert property (watchdog_reset_pulse |=> !watchdog_reset_pulse [*8])
    else $error("watchdog pulse too long");
  a_sda_drive_low: assert property ($rose(sda_oe) |-> !scl_in && sda_out == 1'b0)
    else $error("sda pulled outside scl low");
endmodule : chrb_checker

// ===== testbench/chrb_host.sv
// behavioural i2c controller facing the register bank
`timescale 1ns/1ns
module chrb_host (
  input wire logic clock,
  input wire logic sda,
  output logic scl = 1'b1,
  output logic sda_drv = 1'b1
);
  int half = 10;
  task automatic hold(input int n);
    repeat (n) @(posedge clock);
  endtask : hold
  // sda moves a few clocks after scl falls, so no false start or stop
  task automatic bitx(input logic b, output logic s);
    hold(4);
    sda_drv <= b;
    hold(half);
    scl <= 1'b1;
    hold(half / 2);
    s = sda;
    hold(half - half / 2);
    scl <= 1'b0;
  endtask : bitx
  task automatic start();
    sda_drv <= 1'b0;
    hold(half);
    scl <= 1'b0;
  endtask : start
  task automatic stop();
    hold(4);
    sda_drv <= 1'b0;
    hold(half);
    scl <= 1'b1;
    hold(half);
    sda_drv <= 1'b1;
    hold(half);
  endtask : stop
  task automatic xfer(input logic [7:0] d, output logic [7:0] r, output logic k);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
    bitx(1'b1, s);
    k = !s;
  endtask : xfer
  // offset then data; one write spans far more than 20 us
  task automatic wr(input logic [6:0] a, input logic [7:0] o, d, output logic ok);
    logic [7:0] r;
    logic k0, k1, k2;
    start();
    xfer({a, 1'b0}, r, k0);
    xfer(o, r, k1);
    xfer(d, r, k2);
    stop();
    ok = k0 & k1 & k2;
  endtask : wr
  // offset write, repeated start, one byte then nack
  task automatic rd(input logic [7:0] o, output logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic k0, k1, k2, k3;
    start();
    xfer(8'hD6, r, k0);
    xfer(o, r, k1);
    hold(4);
    sda_drv <= 1'b1;
    hold(half);
    scl <= 1'b1;
    hold(half);
    start();
    xfer(8'hD7, r, k2);
    xfer(8'hFF, d, k3);
    stop();
    ok = k0 & k1 & k2 & !k3;
  endtask : rd
endmodule : chrb_host

// ===== testbench/chrb_register_bank_tb.sv
// self-checking bench for the charger register bank
`timescale 1ns/1ns
module chrb_register_bank_tb;
  import chrb_pkg::*;
  logic clock, resetn, scl_in, sda_drv, sda_out, sda_oe, ext_wr_strobe, watchdog_reset_pulse;
  logic high_impedance_enable, boost_output_enable, charge_enable, boost_cold_select, ok;
  logic reduced_charge_current_force;
  logic [2:0] external_current_limit_pin, ext_wr_offset, input_current_limit, got_ofs;
  logic [2:0] applied_current_limit, minimum_system_voltage, lo;
  logic [3:0] input_voltage_limit;
  logic [5:0] fast_charge_current;
  logic [7:0] status_reg8, status_reg9, status_reg10, ext_rd_data, ext_wr_data, d, got;
  logic [7:0] m [3];
  logic [2:0] defs [4] = '{3'h2, 3'h5, 3'h6, 3'h4};
  chrb_src_t detected_source;
  int num_errors, n_checks, n_pulse, n_strb, e_pulse;
  logic [31:0] seed = 32'hb46996c3;
  wire sda_in = sda_drv & !(sda_oe & !sda_out);
  chrb_register_bank DUT (.clock, .resetn, .scl_in, .sda_in, .sda_out, .sda_oe, .detected_source,
    .external_current_limit_pin, .status_reg8, .status_reg9, .status_reg10, .ext_wr_data,
    .ext_wr_offset, .ext_wr_strobe, .ext_rd_data, .high_impedance_enable, .input_voltage_limit,
    .input_current_limit, .applied_current_limit, .watchdog_reset_pulse, .boost_output_enable,
    .charge_enable, .minimum_system_voltage, .fast_charge_current, .boost_cold_select,
    .reduced_charge_current_force);
  chrb_host host (.clock, .sda(sda_in), .scl(scl_in), .sda_drv);
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // count one-cycle pulses and outer-bank writes
  always @(posedge clock)
  begin
    n_pulse += watchdog_reset_pulse;
    n_strb += ext_wr_strobe;
    if (ext_wr_strobe) got = ext_wr_data;
    if (ext_wr_strobe) got_ofs = ext_wr_offset;
  end
  task automatic chk(input string n, input logic [7:0] e, s);
    n_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic wrc(input logic [7:0] o, v);
    host.wr(7'h6B, o, v, ok);
    chk("write ack", 8'h01, 8'(ok));
  endtask : wrc
  task automatic rdc(input logic [7:0] o, e);
    logic [7:0] r;
    host.rd(o, r, ok);
    chk("read ack", 8'h01, 8'(ok));
    chk("read data", e, r);
  endtask : rdc
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  initial
  begin
    repeat (80000) @(posedge clock);
    num_errors++;
    $display("unexpected run_length exp done got timeout");
    finish_test();
  end
  initial
  begin
    external_current_limit_pin <= 3'h7;
    {status_reg8, status_reg9, status_reg10, ext_rd_data} <= $random(seed);
    for (int s = 0; s < 4; s++)
    begin
      detected_source <= chrb_src_t'(s);
      resetn <= 1'b0;
      repeat (3) @(posedge clock);
      resetn <= 1'b1;
      repeat (8) @(posedge clock);
      m = '{{5'h0B, defs[s]}, 8'h1B, 8'h60};
      for (int i = 0; i < 3; i++) rdc(8'(i), m[i]);
    end
    // random fields; charge code kept at or below 100111
    repeat (4)
    begin
      d = 8'($random(seed));
      external_current_limit_pin <= 3'($random(seed));
      wrc(8'h00, d);
      m[0] = d;
      d = 8'($random(seed));
      d[7:2] = d[7:2] % 6'd40;
      wrc(8'h02, d);
      m[2] = d;
      d = 8'($random(seed)) & 8'h7F;
      e_pulse += d[6];
      wrc(8'h01, d);
      m[1] = {2'b00, d[5:1], 1'b1};
      for (int i = 0; i < 3; i++) rdc(8'(i), m[i]);
      chk("input", {high_impedance_enable, input_voltage_limit, input_current_limit}, m[0]);
      chk("power", 8'({boost_output_enable, charge_enable, minimum_system_voltage}),
        8'({m[1][5], m[1][4] & !m[1][5], m[1][3:1]}));
      chk("charge", {fast_charge_current, boost_cold_select, reduced_charge_current_force}, m[2]);
      lo = (m[0][2:0] < external_current_limit_pin) ? m[0][2:0] : external_current_limit_pin;
      chk("applied", 8'(lo), 8'(applied_current_limit));
    end
    chk("wdog pulses", 8'(e_pulse), 8'(n_pulse));
    host.wr(7'h6A, 8'h00, 8'hFF, ok);
    chk("foreign ack", 8'h00, 8'(ok));
    rdc(8'h00, m[0]);
    wrc(8'h09, 8'h00);
    rdc(8'h09, status_reg9);
    rdc(8'h0C, 8'h00);
    d = 8'($random(seed));
    wrc(8'h04, d);
    chk("outer write", d, got);
    chk("outer offset", 8'h04, 8'(got_ofs));
    chk("outer count", 8'h01, 8'(n_strb));
    rdc(8'h05, ext_rd_data);
    // slow controller for the register reset write
    host.half = 24;
    wrc(8'h01, 8'h80);
    host.half = 10;
    m = '{{5'h0B, 3'h4}, 8'h1B, 8'h60};
    for (int i = 0; i < 3; i++) rdc(8'(i), m[i]);
    finish_test();
  end
endmodule : chrb_register_bank_tb
bind chrb_register_bank chrb_checker chk_i (.clock, .resetn, .scl_in, .sda_out, .sda_oe,
  .ext_wr_strobe, .ext_wr_offset, .input_current_limit, .external_current_limit_pin,
  .applied_current_limit, .watchdog_reset_pulse, .boost_output_enable, .charge_enable,
  .minimum_system_voltage, .fast_charge_current);
